/* rtl/dma_addr_defines.svh */
// constants for the dma address update unit and its cpu end
`ifndef DMA_ADDR_DEFINES_SVH
`define DMA_ADDR_DEFINES_SVH

// address update select codes
`define UPD_FIXED   2'h0
`define UPD_OFFSET  2'h1
`define UPD_INC     2'h2
`define UPD_DEC     2'h3

// access size select codes and their steps
`define SZ_BYTE     2'h0
`define SZ_WORD     2'h1
`define SZ_LONG     2'h2
`define STEP_BYTE   3'h1
`define STEP_WORD   3'h2
`define STEP_LONG   3'h4

// channel transfer modes
`define MODE_NORMAL 2'h0
`define MODE_REPEAT 2'h1
`define MODE_BLOCK  2'h2

// extended repeat area size: zero means no area, n means 2**n bytes
`define AREA_NONE   5'h00

// channel_mode_reg fields
`define MD_EN       0
`define MD_ACT      1
`define MD_ERR      2
`define MD_ESC      3
`define MD_END      4
`define MD_ESCAPE_IRQ_ENABLE     5
`define MD_SZ_LO    6
`define MD_SZ_HI    7
`define MD_MODE_LO  8
`define MD_MODE_HI  9
`define MD_SIDE     10

// address_control_reg fields
`define AC_SAT_LO   0
`define AC_SAT_HI   1
`define AC_DAT_LO   2
`define AC_DAT_HI   3
`define AC_SARA_LO  4
`define AC_SARA_HI  8
`define AC_DARA_LO  9
`define AC_DARA_HI  13
`define AC_SIE      14
`define AC_DIE      15

`endif

/* rtl/dma_addr_pkg.sv */
// types shared by the dma address update unit, its cpu end and their interface
package dma_addr_pkg;
  typedef enum logic [2:0] {SEL_SRC, SEL_DST, SEL_OFS, SEL_CNT, SEL_BSZ, SEL_ACR, SEL_MODE} reg_sel_t;
  typedef enum logic [1:0] {PH_IDLE, PH_READ, PH_WRITE} phase_t;
  typedef enum logic [1:0] {CP_IDLE, CP_ADDR, CP_DATA} cpu_phase_t;
endpackage : dma_addr_pkg

/* rtl/dma_cpu_if.sv */
// register port between the cpu end and the dma address update unit
`timescale 1ns/1ns
interface dma_cpu_if
  import dma_addr_pkg::*;
;
  logic        reg_wr;
  reg_sel_t    reg_sel;
  logic [31:0] reg_wdata;
  reg_sel_t    rd_sel;
  logic [31:0] rd_data;
  logic        xfer_enable;
  logic        escape_irq;
  logic        wrap_irq;
  logic        repeat_irq;

  modport device (
    input  reg_wr,
    input  reg_sel,
    input  reg_wdata,
    input  rd_sel,
    output rd_data,
    output xfer_enable,
    output escape_irq,
    output wrap_irq,
    output repeat_irq
  );

  modport cpu (
    output reg_wr,
    output reg_sel,
    output reg_wdata,
    output rd_sel,
    input  rd_data,
    input  xfer_enable,
    input  escape_irq,
    input  wrap_irq,
    input  repeat_irq
  );
endinterface : dma_cpu_if

/* rtl/addr_step_calc.sv */
// next address for one side: fixed, offset, increment or decrement, with ring wrap
`timescale 1ns/1ns
`include "dma_addr_defines.svh"
module addr_step_calc (
  input  wire logic [31:0] addr,
  input  wire logic [1:0]  update_sel,
  input  wire logic [2:0]  step,
  input  wire logic [31:0] offset,
  input  wire logic [4:0]  area_size,
  output logic      [31:0] next_addr,
  output logic             overflow
);
  logic [31:0] raw;
  logic [31:0] mask;

  always_comb begin
    unique case (update_sel)
      `UPD_FIXED:  raw = addr;
      `UPD_OFFSET: raw = addr + offset;
      `UPD_INC:    raw = addr + {29'h000_0000, step};
      `UPD_DEC:    raw = addr - {29'h000_0000, step};
    endcase
    mask = (32'h0000_0001 << area_size) - 32'h0000_0001;
    if (area_size == `AREA_NONE) begin
      next_addr = raw;
      overflow  = 1'b0;
    end else begin
      // upper bits stay put so the address runs round inside the area
      next_addr = (addr & ~mask) | (raw & mask);
      overflow  = |((raw ^ addr) & ~mask);
    end
  end
endmodule : addr_step_calc

/* rtl/dma_addr_unit.sv */
// dma channel address update unit: address stepping, ring areas, counters and flags
`timescale 1ns/1ns
`include "dma_addr_defines.svh"

// What this block does
// - separate wrap area size per source/destination side
// - wrap area keeps upper address bits fixed
// - enabled wrap overflow sets escape, clears enable
// - overflow stop with escape enable raises wrap irq
// - software re-enable resumes the stopped transfer
// - block mode defers overflow stop to block end
// - software uses power-of-two or aligned block sizes; cpu end refuses block mode with SIE/DIE unless reload is a power of two
// - source update field: fixed, offset, increment, decrement
// - access size byte/word/long steps 1/2/4
// - offset added once per access unit
// - only addition; software loads negative offsets
// - source address driven first, updated afterwards
// - misaligned reads split, then start address stepped
// - block/repeat end restores area side start address
// - repeat end raises interrupt and pauses
// - software reads addresses whole, never writes active
// - hardware updates addresses, counters and flags
// - destination update field uses same encoding
// - escape irq when escape flag and enable
module dma_addr_unit
  import dma_addr_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        rst_n,
  dma_cpu_if.device        cpu,
  input  wire logic        xfer_req,
  input  wire logic        error_in,
  input  wire logic        bus_ack,
  output logic             bus_valid,
  output logic             bus_write,
  output logic      [31:0] bus_addr,
  output logic      [1:0]  bus_size,
  output logic             active
);
  typedef struct packed {
    logic [31:0] src;
    logic [31:0] dst;
    logic [31:0] ofs;
    logic [31:0] cnt;
    logic [31:0] start_src;
    logic [31:0] start_dst;
    logic [31:0] cur;
    logic [15:0] bsz_reload;
    logic [15:0] bsz_cnt;
    logic [1:0]  src_upd;
    logic [1:0]  dst_upd;
    logic [4:0]  src_area;
    logic [4:0]  dst_area;
    logic        src_ie;
    logic        dst_ie;
    logic [1:0]  size;
    logic [1:0]  xmode;
    logic        side;
    logic        en;
    logic        act;
    logic        err;
    logic        esc;
    logic        done;
    logic        escape_irq_enable;
    logic [2:0]  rem;
    phase_t      phase;
    logic        src_ov;
    logic        pend;
    logic        wrap_cause;
    logic        rpt_cause;
    logic [31:0] rd_data;
    logic        bus_valid;
    logic        bus_write;
    logic [31:0] bus_addr;
    logic [1:0]  bus_size;
    logic        irq_esc;
    logic        irq_wrap;
    logic        irq_rpt;
  } state_t;

  state_t      s;
  state_t      n;
  logic [31:0] src_step;
  logic        src_ov_w;
  logic [31:0] dst_step;
  logic        dst_ov_w;
  logic [2:0]  unit_bytes;
  logic [2:0]  piece_bytes;
  logic [31:0] unit32;
  logic        bsz_last;
  logic        wrap_hit;
  logic        stop_wrap;
  logic        stop_rpt;
  logic        stop_done;
  logic [31:0] mode_word;
  logic [31:0] acr_word;
  logic [31:0] w;

  function automatic logic [2:0] size_bytes(input logic [1:0] sz);
    case (sz)
      `SZ_WORD: size_bytes = `STEP_WORD;
      `SZ_LONG: size_bytes = `STEP_LONG;
      default:  size_bytes = `STEP_BYTE;
    endcase
  endfunction : size_bytes

  // widest aligned piece that still fits in what is left of the unit
  function automatic logic [1:0] piece(input logic [31:0] a, input logic [2:0] r);
    if (r >= `STEP_LONG && a[1:0] == 2'h0) begin
      piece = `SZ_LONG;
    end else if (r >= `STEP_WORD && !a[0]) begin
      piece = `SZ_WORD;
    end else begin
      piece = `SZ_BYTE;
    end
  endfunction : piece

  assign unit_bytes  = size_bytes(s.size);
  assign piece_bytes = size_bytes(s.bus_size);
  assign unit32      = {29'h000_0000, unit_bytes};
  assign bsz_last    = (s.xmode != `MODE_NORMAL) && (s.bsz_cnt == 16'h0001);
  assign w           = cpu.reg_wdata;

  addr_step_calc src_calc (
    .addr       (s.src),
    .update_sel (s.src_upd),
    .step       (unit_bytes),
    .offset     (s.ofs),
    .area_size  (s.src_area),
    .next_addr  (src_step),
    .overflow   (src_ov_w)
  );

  addr_step_calc dst_calc (
    .addr       (s.dst),
    .update_sel (s.dst_upd),
    .step       (unit_bytes),
    .offset     (s.ofs),
    .area_size  (s.dst_area),
    .next_addr  (dst_step),
    .overflow   (dst_ov_w)
  );

  always_comb begin
    mode_word                           = 32'h0000_0000;
    mode_word[`MD_EN]                   = s.en;
    mode_word[`MD_ACT]                  = s.act;
    mode_word[`MD_ERR]                  = s.err;
    mode_word[`MD_ESC]                  = s.esc;
    mode_word[`MD_END]                  = s.done;
    mode_word[`MD_ESCAPE_IRQ_ENABLE]                 = s.escape_irq_enable;
    mode_word[`MD_SZ_HI:`MD_SZ_LO]      = s.size;
    mode_word[`MD_MODE_HI:`MD_MODE_LO]  = s.xmode;
    mode_word[`MD_SIDE]                 = s.side;
    acr_word                            = 32'h0000_0000;
    acr_word[`AC_SAT_HI:`AC_SAT_LO]     = s.src_upd;
    acr_word[`AC_DAT_HI:`AC_DAT_LO]     = s.dst_upd;
    acr_word[`AC_SARA_HI:`AC_SARA_LO]   = s.src_area;
    acr_word[`AC_DARA_HI:`AC_DARA_LO]   = s.dst_area;
    acr_word[`AC_SIE]                   = s.src_ie;
    acr_word[`AC_DIE]                   = s.dst_ie;
  end

  always_comb begin
    n         = s;
    stop_wrap = 1'b0;
    stop_rpt  = 1'b0;
    stop_done = 1'b0;
    wrap_hit  = s.src_ov | (dst_ov_w & s.dst_ie);

    unique case (s.phase)
      PH_IDLE: begin
        if (s.en && xfer_req) begin
          n.phase     = PH_READ;
          n.cur       = s.src;
          n.rem       = unit_bytes;
          n.bus_valid = 1'b1;
          n.bus_write = 1'b0;
          n.bus_addr  = s.src;
          n.bus_size  = piece(s.src, unit_bytes);
        end
      end
      PH_READ: begin
        if (bus_ack) begin
          if (s.rem == piece_bytes) begin
            // the register moves only once the whole unit has been read
            n.src       = (bsz_last && !s.side) ? s.start_src : src_step;
            n.src_ov    = src_ov_w & s.src_ie;
            n.phase     = PH_WRITE;
            n.bus_write = 1'b1;
            n.bus_addr  = s.dst;
            n.bus_size  = s.size;
          end else begin
            n.cur      = s.cur + {29'h000_0000, piece_bytes};
            n.rem      = s.rem - piece_bytes;
            n.bus_addr = n.cur;
            n.bus_size = piece(n.cur, n.rem);
          end
        end
      end
      PH_WRITE: begin
        if (bus_ack) begin
          n.phase     = PH_IDLE;
          n.bus_valid = 1'b0;
          n.bus_write = 1'b0;
          n.src_ov    = 1'b0;
          n.dst       = (bsz_last && s.side) ? s.start_dst : dst_step;
          if (s.xmode != `MODE_NORMAL) begin
            n.bsz_cnt = bsz_last ? s.bsz_reload : s.bsz_cnt - 16'h0001;
          end
          if (s.cnt != 32'h0000_0000) begin
            n.cnt     = (s.cnt <= unit32) ? 32'h0000_0000 : s.cnt - unit32;
            stop_done = (s.cnt <= unit32);
          end
          if (s.xmode == `MODE_BLOCK && !bsz_last) begin
            n.pend = s.pend | wrap_hit;
          end else if (wrap_hit || s.pend) begin
            stop_wrap = 1'b1;
            n.pend    = 1'b0;
          end
          stop_rpt = (s.xmode == `MODE_REPEAT) && bsz_last;
        end
      end
      default: n.phase = PH_IDLE;
    endcase

    // software writes win over the hardware address update
    if (cpu.reg_wr) begin
      unique case (cpu.reg_sel)
        SEL_SRC: begin
          n.src       = w;
          n.start_src = w;
        end
        SEL_DST: begin
          n.dst       = w;
          n.start_dst = w;
        end
        SEL_OFS: n.ofs = w;
        SEL_CNT: n.cnt = w;
        SEL_BSZ: begin
          n.bsz_reload = w[31:16];
          n.bsz_cnt    = w[15:0];
        end
        SEL_ACR: begin
          n.src_upd  = w[`AC_SAT_HI:`AC_SAT_LO];
          n.dst_upd  = w[`AC_DAT_HI:`AC_DAT_LO];
          n.src_area = w[`AC_SARA_HI:`AC_SARA_LO];
          n.dst_area = w[`AC_DARA_HI:`AC_DARA_LO];
          n.src_ie   = w[`AC_SIE];
          n.dst_ie   = w[`AC_DIE];
        end
        SEL_MODE: begin
          n.en    = w[`MD_EN];
          n.err   = s.err & w[`MD_ERR];
          n.esc   = s.esc & w[`MD_ESC];
          n.done  = s.done & w[`MD_END];
          n.escape_irq_enable  = w[`MD_ESCAPE_IRQ_ENABLE];
          n.size  = w[`MD_SZ_HI:`MD_SZ_LO];
          n.xmode = w[`MD_MODE_HI:`MD_MODE_LO];
          n.side  = w[`MD_SIDE];
          if (w[`MD_EN] && !s.en) begin
            // resuming from a stop drops the old cause
            n.esc        = 1'b0;
            n.done       = 1'b0;
            n.wrap_cause = 1'b0;
            n.rpt_cause  = 1'b0;
          end
        end
        default: ;
      endcase
    end

    // hardware sets beat a clear written in the same cycle
    if (stop_wrap || stop_rpt) begin
      n.esc        = 1'b1;
      n.en         = 1'b0;
      n.wrap_cause = s.wrap_cause | stop_wrap;
      n.rpt_cause  = s.rpt_cause | stop_rpt;
    end
    if (stop_done) begin
      n.done = 1'b1;
      n.en   = 1'b0;
    end
    if (error_in) begin
      n.err = 1'b1;
      n.en  = 1'b0;
    end

    n.act      = (n.phase != PH_IDLE);
    n.irq_esc  = n.esc & n.escape_irq_enable;
    n.irq_wrap = n.esc & n.escape_irq_enable & n.wrap_cause;
    n.irq_rpt  = n.esc & n.escape_irq_enable & n.rpt_cause;

    unique case (cpu.rd_sel)
      SEL_SRC:  n.rd_data = s.src;
      SEL_DST:  n.rd_data = s.dst;
      SEL_OFS:  n.rd_data = s.ofs;
      SEL_CNT:  n.rd_data = s.cnt;
      SEL_BSZ:  n.rd_data = {s.bsz_reload, s.bsz_cnt};
      SEL_ACR:  n.rd_data = acr_word;
      SEL_MODE: n.rd_data = mode_word;
      default:  n.rd_data = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      s <= '0;
    end else begin
      s <= n;
    end
  end

  assign bus_valid       = s.bus_valid;
  assign bus_write       = s.bus_write;
  assign bus_addr        = s.bus_addr;
  assign bus_size        = s.bus_size;
  assign active          = s.act;
  assign cpu.rd_data     = s.rd_data;
  assign cpu.xfer_enable = s.en;
  assign cpu.escape_irq  = s.irq_esc;
  assign cpu.wrap_irq    = s.irq_wrap;
  assign cpu.repeat_irq  = s.irq_rpt;
endmodule : dma_addr_unit

/* rtl/dma_cpu_end.sv */
// cpu end: issues register accesses to the dma address update unit and guards them
`timescale 1ns/1ns
`include "dma_addr_defines.svh"
module dma_cpu_end
  import dma_addr_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        rst_n,
  dma_cpu_if.cpu           dev,
  input  wire logic        cmd_valid,
  input  wire logic        cmd_write,
  input  wire reg_sel_t    cmd_sel,
  input  wire logic [31:0] cmd_data,
  input  wire logic        cmd_negate,
  output logic             cmd_ready,
  output logic             cmd_done,
  output logic             cmd_refused,
  output logic      [31:0] rsp_data,
  output logic             irq_escape,
  output logic             irq_wrap,
  output logic             irq_repeat
);
  typedef struct packed {
    cpu_phase_t  phase;
    logic        ready;
    logic        done;
    logic        refused;
    logic [31:0] rsp;
    logic        reg_wr;
    reg_sel_t    reg_sel;
    logic [31:0] wdata;
    reg_sel_t    rd_sel;
    logic        wrap_ie;
    logic        bsz_pow2;
    logic        irq_esc;
    logic        irq_wrap;
    logic        irq_rpt;
  } state_t;

  state_t      s;
  state_t      n;
  logic [31:0] data;
  logic        busy_reg;
  logic        bad_block;
  logic [15:0] reload;

  always_comb begin
    n         = s;
    n.reg_wr  = 1'b0;
    n.done    = 1'b0;
    n.refused = 1'b0;
    data      = cmd_negate ? (~cmd_data + 32'h0000_0001) : cmd_data;
    reload    = data[31:16];
    // only the mode register may be touched while the channel runs or is being started
    busy_reg  = (dev.xfer_enable || (s.reg_wr && s.reg_sel == SEL_MODE && s.wdata[`MD_EN]))
                && (cmd_sel != SEL_MODE);
    bad_block = (cmd_sel == SEL_MODE) && data[`MD_EN] && s.wrap_ie && !s.bsz_pow2
                && (data[`MD_MODE_HI:`MD_MODE_LO] == `MODE_BLOCK);
    unique case (s.phase)
      CP_IDLE: begin
        if (cmd_valid && cmd_write) begin
          n.done = 1'b1;
          if (busy_reg || bad_block) begin
            n.refused = 1'b1;
          end else begin
            n.reg_wr  = 1'b1;
            n.reg_sel = cmd_sel;
            n.wdata   = data;
            if (cmd_sel == SEL_ACR) begin
              n.wrap_ie = data[`AC_SIE] | data[`AC_DIE];
            end
            if (cmd_sel == SEL_BSZ) begin
              n.bsz_pow2 = (reload != 16'h0000) && ((reload & (reload - 16'h0001)) == 16'h0000);
            end
          end
        end else if (cmd_valid) begin
          n.rd_sel = cmd_sel;
          n.phase  = CP_ADDR;
        end
      end
      CP_ADDR: n.phase = CP_DATA;
      CP_DATA: begin
        n.rsp   = dev.rd_data;
        n.done  = 1'b1;
        n.phase = CP_IDLE;
      end
      default: n.phase = CP_IDLE;
    endcase
    n.ready    = (n.phase == CP_IDLE);
    n.irq_esc  = dev.escape_irq;
    n.irq_wrap = dev.wrap_irq;
    n.irq_rpt  = dev.repeat_irq;
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      s <= '0;
    end else begin
      s <= n;
    end
  end

  assign cmd_ready     = s.ready;
  assign cmd_done      = s.done;
  assign cmd_refused   = s.refused;
  assign rsp_data      = s.rsp;
  assign irq_escape    = s.irq_esc;
  assign irq_wrap      = s.irq_wrap;
  assign irq_repeat    = s.irq_rpt;
  assign dev.reg_wr    = s.reg_wr;
  assign dev.reg_sel   = s.reg_sel;
  assign dev.reg_wdata = s.wdata;
  assign dev.rd_sel    = s.rd_sel;
endmodule : dma_cpu_end

/* testbench/dma_addr_sva.sv */
// assertions on the register port between the cpu end and the address unit
`timescale 1ns/1ns
`include "dma_addr_defines.svh"
module dma_addr_sva
  import dma_addr_pkg::*;
(
  input wire logic        clk,
  input wire logic        rst_n,
  input wire logic        reg_wr,
  input wire reg_sel_t    reg_sel,
  input wire logic [31:0] reg_wdata,
  input wire reg_sel_t    rd_sel,
  input wire logic [31:0] rd_data,
  input wire logic        xfer_enable,
  input wire logic        escape_irq,
  input wire logic        wrap_irq,
  input wire logic        repeat_irq
);
  typedef struct packed {
    logic        escape_irq_enable;
    logic [31:0] ofs;
    logic [15:0] acr;
  } shadow_t;
  shadow_t sh;
  shadow_t next_sh;
  logic    md_wr;
  logic    en_wr;
  assign md_wr = reg_wr && (reg_sel == SEL_MODE);
  assign en_wr = md_wr && reg_wdata[`MD_EN] && !xfer_enable;
  // copies of the registers that only the cpu changes
  always_comb begin
    next_sh = sh;
    if (md_wr) next_sh.escape_irq_enable = reg_wdata[`MD_ESCAPE_IRQ_ENABLE];
    if (reg_wr && reg_sel == SEL_OFS) next_sh.ofs = reg_wdata;
    if (reg_wr && reg_sel == SEL_ACR) next_sh.acr = reg_wdata[15:0];
  end
  always_ff @(posedge clk) begin
    if (!rst_n) sh <= '0;
    else sh <= next_sh;
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  property p_wr_guard;
    reg_wr && reg_sel != SEL_MODE |-> !xfer_enable;
  endproperty
  a_wr_guard: assert property (p_wr_guard) else $error("write while enabled");
  property p_enable_set;
    en_wr |=> xfer_enable;
  endproperty
  a_enable_set: assert property (p_enable_set) else $error("enable not set");
  property p_resume_clear;
    en_wr |-> ##2 !wrap_irq && !repeat_irq;
  endproperty
  a_resume_clear: assert property (p_resume_clear) else $error("cause kept on resume");
  property p_esc_cause;
    (wrap_irq || repeat_irq) |-> escape_irq;
  endproperty
  a_esc_cause: assert property (p_esc_cause) else $error("cause without escape irq");
  property p_esc_enable;
    escape_irq |-> sh.escape_irq_enable || $past(sh.escape_irq_enable);
  endproperty
  a_esc_enable: assert property (p_esc_enable) else $error("escape irq while masked");
  property p_stop;
    $rose(escape_irq) |-> !xfer_enable;
  endproperty
  a_stop: assert property (p_stop) else $error("escape without stop");
  property p_ofs_read;
    $past(rd_sel) == SEL_OFS |-> rd_data == $past(sh.ofs);
  endproperty
  a_ofs_read: assert property (p_ofs_read) else $error("offset register wrong");
  property p_acr_read;
    $past(rd_sel) == SEL_ACR |-> rd_data[15:0] == $past(sh.acr);
  endproperty
  a_acr_read: assert property (p_acr_read) else $error("address control wrong");
endmodule : dma_addr_sva

/* testbench/tb.sv */
// bench: cpu end and address unit joined by their port, bus side answered here
`timescale 1ns/1ns
`include "dma_addr_defines.svh"
module tb
  import dma_addr_pkg::*;
;
  logic        clk = 1'b0;
  logic        rst_n = 1'b0;
  logic        xfer_req = 1'b0;
  logic        error_in = 1'b0;
  logic        bus_ack = 1'b0;
  logic        cmd_valid = 1'b0;
  logic        cmd_write = 1'b0;
  reg_sel_t    cmd_sel = SEL_SRC;
  logic [31:0] cmd_data = 32'h0000_0000;
  logic        cmd_negate = 1'b0;
  logic        bus_valid, bus_write, active, cmd_ready, cmd_done, cmd_refused;
  logic        irq_escape, irq_wrap, irq_repeat;
  logic [1:0]  bus_size;
  logic [31:0] bus_addr, rsp_data, rd, sa, da, o, st;
  logic [31:0] seed = 32'h0000_2208;
  logic [34:0] pcs[$];
  int          mismatches = 0;
  int          cmp_count = 0;
  dma_cpu_if dma_cpu_if_inst ();
  dma_addr_unit dma_addr_unit_inst (
    .clk(clk), .rst_n(rst_n), .cpu(dma_cpu_if_inst), .xfer_req(xfer_req), .error_in(error_in),
    .bus_ack(bus_ack), .bus_valid(bus_valid), .bus_write(bus_write), .bus_addr(bus_addr),
    .bus_size(bus_size), .active(active)
  );
  dma_cpu_end dma_cpu_end_inst (
    .clk(clk), .rst_n(rst_n), .dev(dma_cpu_if_inst), .cmd_valid(cmd_valid), .cmd_write(cmd_write),
    .cmd_sel(cmd_sel), .cmd_data(cmd_data), .cmd_negate(cmd_negate), .cmd_ready(cmd_ready),
    .cmd_done(cmd_done), .cmd_refused(cmd_refused), .rsp_data(rsp_data), .irq_escape(irq_escape),
    .irq_wrap(irq_wrap), .irq_repeat(irq_repeat)
  );
  dma_addr_sva dma_addr_sva_inst (
    .clk(clk), .rst_n(rst_n), .reg_wr(dma_cpu_if_inst.reg_wr), .reg_sel(dma_cpu_if_inst.reg_sel),
    .reg_wdata(dma_cpu_if_inst.reg_wdata), .rd_sel(dma_cpu_if_inst.rd_sel),
    .rd_data(dma_cpu_if_inst.rd_data), .xfer_enable(dma_cpu_if_inst.xfer_enable),
    .escape_irq(dma_cpu_if_inst.escape_irq), .wrap_irq(dma_cpu_if_inst.wrap_irq),
    .repeat_irq(dma_cpu_if_inst.repeat_irq)
  );
  always #5 clk = ~clk;
  function automatic logic [31:0] lfsr(input logic [31:0] x);
    return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
  endfunction : lfsr
  // next address of one side, upper bits held inside a ring area
  function automatic logic [31:0] nx(input logic [31:0] a, input logic [1:0] u, input logic [31:0] s,
                                     input logic [31:0] f, input logic [4:0] ar);
    logic [31:0] n;
    logic [31:0] m;
    n = (u == `UPD_OFFSET) ? a + f : (u == `UPD_INC) ? a + s : (u == `UPD_DEC) ? a - s : a;
    m = (ar == 5'h00) ? 32'hffff_ffff : ~(32'hffff_ffff << ar);
    return (a & ~m) | (n & m);
  endfunction : nx
  task automatic stop_test();
    $display("compares %0d mismatches %0d", cmp_count, mismatches);
    if (mismatches == 0 && cmp_count > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : stop_test
  task automatic check(input string what, input logic [34:0] seen, input logic [34:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      mismatches++;
      $display("[ERR] %s expected %h seen %h", what, exp, seen);
    end
  endtask : check
  task automatic tmo(input string what);
    mismatches++;
    $display("[ERR] %s expected handshake seen timeout", what);
    stop_test();
  endtask : tmo
  task automatic cmd(input logic w, input reg_sel_t s, input logic [31:0] d, input logic ng, input logic rf);
    int n;
    @(negedge clk);
    for (n = 0; n < 20 && !cmd_ready; n++) @(negedge clk);
    if (cmd_ready !== 1'b1) tmo("cmd_ready");
    cmd_valid = 1'b1;
    cmd_write = w;
    cmd_sel = s;
    cmd_data = d;
    cmd_negate = ng;
    @(negedge clk);
    cmd_valid = 1'b0;
    for (n = 0; n < 10 && !cmd_done; n++) @(negedge clk);
    if (cmd_done !== 1'b1) tmo("cmd_done");
    if (w) check("refused", 35'(cmd_refused), 35'(rf));
    rd = rsp_data;
  endtask : cmd
  task automatic wr(input reg_sel_t s, input logic [31:0] d);
    cmd(1'b1, s, d, 1'b0, 1'b0);
  endtask : wr
  task automatic rdchk(input string what, input reg_sel_t s, input logic [31:0] e);
    cmd(1'b0, s, 32'h0000_0000, 1'b0, 1'b0);
    check(what, 35'(rd), 35'(e));
  endtask : rdchk
  task automatic en_chk(input logic e);
    @(negedge clk);
    check("enable", 35'(dma_cpu_if_inst.xfer_enable), 35'(e));
  endtask : en_chk
  task automatic setup(input logic [31:0] s, d, f, ac, bs, md);
    wr(SEL_MODE, 32'h0000_0000);
    wr(SEL_SRC, s);
    wr(SEL_DST, d);
    wr(SEL_OFS, f);
    wr(SEL_ACR, ac);
    wr(SEL_BSZ, bs);
    wr(SEL_CNT, 32'h0000_1000);
    wr(SEL_MODE, md);
  endtask : setup
  // one access unit, acked after random stalls; pieces recorded in order
  task automatic unit();
    int n;
    pcs.delete();
    @(negedge clk);
    xfer_req = 1'b1;
    for (n = 0; n < 60; n++) begin
      @(negedge clk);
      seed = lfsr(seed);
      if (bus_ack) begin
        bus_ack = 1'b0;
        if (pcs[$][34]) break;
      end else if (bus_valid && seed[0]) begin
        xfer_req = 1'b0;
        pcs.push_back({bus_write, bus_addr, bus_size});
        check("active", 35'(active), 35'(1'b1));
        bus_ack = 1'b1;
      end
    end
    if (n == 60) tmo("unit");
  endtask : unit
  task automatic pc(input int i, input logic w, input logic [31:0] a, input logic [1:0] z);
    if (pcs.size() <= i) check("piece count", 35'(pcs.size()), 35'(i + 1));
    else check("piece", pcs[i], {w, a, z});
  endtask : pc
  initial begin
    repeat (3) @(negedge clk);
    rst_n = 1'b1;
    for (int s = 0; s < 7; s++) rdchk("reset value", reg_sel_t'(s), 32'h0000_0000);
    seed = lfsr(seed);
    cmd(1'b1, SEL_OFS, seed, 1'b1, 1'b0);
    rdchk("negated offset", SEL_OFS, ~seed + 32'h0000_0001);
    $display("test registers done");
    for (int u = 0; u < 4; u++) begin
      for (int z = 0; z < 3; z++) begin
        seed = lfsr(seed);
        sa = (u == 3) ? 32'h0000_0000 : {seed[31:3], 3'h0};
        da = {seed[7:0], seed[31:11], 3'h0};
        o = {seed[15:0], seed[31:19], 3'h0};
        st = 32'h0000_0001 << z;
        setup(sa, da, o, {28'h0, 2'(u), 2'(u)}, 32'h0000_0000, {24'h0, 2'(z), 6'h01});
        for (int k = 0; k < 2; k++) begin
          unit();
          pc(0, 1'b0, sa, 2'(z));
          pc(1, 1'b1, da, 2'(z));
          sa = nx(sa, 2'(u), st, o, 5'h00);
          da = nx(da, 2'(u), st, o, 5'h00);
        end
        rdchk("source step", SEL_SRC, sa);
        rdchk("dest step", SEL_DST, da);
      end
    end
    $display("test stepping done");
    sa = {seed[31:4], 4'h1};
    setup(sa, da, 32'h0000_0000, 32'h0000_000a, 32'h0000_0000, 32'h0000_0081);
    unit();
    pc(0, 1'b0, sa, 2'h0);
    pc(1, 1'b0, sa + 32'h0000_0001, 2'h1);
    pc(2, 1'b0, sa + 32'h0000_0003, 2'h0);
    pc(3, 1'b1, da, 2'h2);
    rdchk("split source", SEL_SRC, sa + 32'h0000_0004);
    $display("test split done");
    sa = {seed[31:4], 4'he};
    setup(sa, da, 32'h0000_0000, 32'h0000_404a, 32'h0000_0000, 32'h0000_0021);
    rdchk("area control", SEL_ACR, 32'h0000_404a);
    unit();
    en_chk(1'b1);
    cmd(1'b1, SEL_SRC, 32'h0000_0000, 1'b0, 1'b1);
    rdchk("source kept", SEL_SRC, sa + 32'h0000_0001);
    unit();
    pc(0, 1'b0, sa + 32'h0000_0001, 2'h0);
    en_chk(1'b0);
    repeat (3) @(negedge clk);
    check("wrap irqs", 35'({irq_escape, irq_wrap, irq_repeat}), 35'(3'h6));
    rdchk("wrapped source", SEL_SRC, {sa[31:4], 4'h0});
    wr(SEL_MODE, 32'h0000_0021);
    en_chk(1'b1);
    repeat (3) @(negedge clk);
    check("irqs cleared", 35'({irq_escape, irq_wrap}), 35'(2'h0));
    unit();
    pc(0, 1'b0, {sa[31:4], 4'h0}, 2'h0);
    $display("test wrap done");
    sa = {seed[31:4], 4'h4};
    setup(sa, da, 32'h0000_0000, 32'h0000_000a, 32'h0002_0002, 32'h0000_0121);
    unit();
    unit();
    pc(0, 1'b0, sa + 32'h0000_0001, 2'h0);
    en_chk(1'b0);
    repeat (3) @(negedge clk);
    check("repeat irqs", 35'({irq_escape, irq_wrap, irq_repeat}), 35'(3'h5));
    rdchk("source restored", SEL_SRC, sa);
    wr(SEL_MODE, 32'h0000_0121);
    unit();
    pc(0, 1'b0, sa, 2'h0);
    wr(SEL_MODE, 32'h0000_0000);
    wr(SEL_ACR, 32'h0000_400a);
    wr(SEL_BSZ, 32'h0003_0003);
    cmd(1'b1, SEL_MODE, 32'h0000_0201, 1'b0, 1'b1);
    en_chk(1'b0);
    sa = {seed[31:4], 4'hf};
    setup(sa, da, 32'h0000_0000, 32'h0000_404a, 32'h0002_0002, 32'h0000_0221);
    unit();
    en_chk(1'b1);
    unit();
    pc(0, 1'b0, {sa[31:4], 4'h0}, 2'h0);
    en_chk(1'b0);
    $display("test repeat done");
    setup(sa, da, 32'h0000_0000, 32'h0000_000a, 32'h0000_0000, 32'h0000_0001);
    @(negedge clk);
    error_in = 1'b1;
    @(negedge clk);
    error_in = 1'b0;
    en_chk(1'b0);
    cmd(1'b0, SEL_MODE, 32'h0000_0000, 1'b0, 1'b0);
    check("error flag", 35'(rd[`MD_ERR]), 35'(1'b1));
    $display("test error done");
    stop_test();
  end
endmodule : tb
